// ===== logic/counter_array_cfg.svh
// Address map, reset values, field positions and divider counts of the counter array.
`ifndef COUNTER_ARRAY_CFG_SVH
`define COUNTER_ARRAY_CFG_SVH
`define CA_ADDR_CTRL    8'hd8
`define CA_ADDR_MODE    8'hd9
`define CA_ADDR_CNT_LO  8'he0
`define CA_ADDR_CNT_HI  8'he1
`define CA_ADDR_CPM0    8'hc0
`define CA_ADDR_CPL0    8'hc8
`define CA_ADDR_CPH0    8'hd0
`define CA_NUM_MOD      6
`define CA_WDT_MOD      5
`define CA_CTRL_RESET   8'h00
`define CA_MODE_RESET   8'h40
`define CA_CTRL_OVF     7
`define CA_CTRL_RUN     6
`define CA_DIV12_LAST   4'hb
`define CA_DIV4_LAST    2'h3
`define CA_EXT8_LAST    3'h7
`define CA_CNT_MAX      16'hffff
`define CA_LOW_MAX      8'hff
`endif

// ===== logic/counter_array_pkg.sv
// Types shared by the counter array logic.
package counter_array_pkg;
  typedef struct packed {
    logic       pwm16_select;
    logic       compare_enable;
    logic       cap_pos;
    logic       cap_neg;
    logic       match_flag_enable;
    logic       toggle_enable;
    logic       pwm_enable;
    logic       flag_irq_enable;
  } module_mode_s;
  typedef struct packed {
    logic       idle_suspend;
    logic       wdt_enable_bit;
    logic       wdt_lock;
    logic       unused;
    logic [2:0] clock_select;
    logic       overflow_irq_enable;
  } mode_reg_s;
endpackage

// ===== logic/counter_array_pwm16_watchdog.sv
// Counter array core: 16-bit counter, 16-bit PWM modules and module 5 watchdog.
`timescale 1ns/1ns
`include "counter_array_cfg.svh"
// What this block does
// (R1) Output high on match, low on overflow
// (R2) Mode needs compare, pwm and pwm16 bits
// (R3) Ignores shared cycle length setting
// (R4) Match sets module flag when enabled
// (R5) Software syncs duty writes to match
// (R6) Low write clears, high write sets compare
// (R7) Duty is 65536 minus compare value
// (R8) Counter rollover sets overflow flag
// (R9) Matches set sticky module flags
// (R10) Run bit starts and stops counter
// (R11) Module 5 compares high byte, holds offset
// (R12) Watchdog on after reset, 256 clocks
// (R13) Watchdog freezes counter, clocks, module 5
// (R14) Run writes ignored, reads software value
// (R15) Update write loads high plus offset
// (R16) Low overflow on match fires reset
// (R17) Timeout is offset pages plus remainder
// (R18) Writing module 5 flag forces reset
// (R19) Enable or lock turns watchdog on
// (R20) Software configures watchdog in order
// (R21) Clock select picks counter timebase
// (R22) Idle suspend halts during CPU idle
// (R23) Reset request is one cycle, state resets
module counter_array_pwm16_watchdog (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_we,
  output logic      [7:0] sfr_rdata,
  input  wire logic       idle_mode,
  input  wire logic       timer0_ovf,
  input  wire logic       ext_count_in,
  input  wire logic       ext_clk,
  output logic      [5:0] pwm_out,
  output logic            counter_array_irq,
  output logic            wdt_reset_req
);
  localparam int NM = `CA_NUM_MOD;
  localparam int W5 = `CA_WDT_MOD;

  // A watchdog reset returns every register here to its reset value on the cycle after the request.
  logic rst;
  assign rst = sys_rst | wdt_reset_req; // R23

  counter_array_pkg::mode_reg_s    mode,  next_mode;
  counter_array_pkg::module_mode_s mmode [NM];
  counter_array_pkg::module_mode_s next_mmode [NM];
  logic [15:0] cmp      [NM];
  logic [15:0] next_cmp [NM];
  logic        next_pwm [NM];
  logic        match    [NM];
  logic [15:0] count,    next_count;
  logic        ovf_flag, next_ovf_flag;
  logic        run_ctl,  next_run_ctl;
  logic [5:0]  mflag,    next_mflag;
  logic [3:0]  div12,    next_div12;
  logic [1:0]  div4,     next_div4;
  logic [2:0]  ext8,     next_ext8;
  logic        eci_d,    extc_d;
  logic        tick,     wdt_en,  wdt_fire, force_rst;
  logic [7:0]  wdt_load, next_rdata;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  // Dividers run free so that a source switch sees no stale phase restart.
  always_comb begin
    next_div12 = (div12 == `CA_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
    next_div4  = div4 + 2'h1;
    next_ext8  = ext8;
    if (ext_clk && !extc_d) begin
      next_ext8 = ext8 + 3'h1;
    end
    case (mode.clock_select) // R21
      3'h0: tick = (div12 == `CA_DIV12_LAST);
      3'h1: tick = (div4 == `CA_DIV4_LAST);
      3'h2: tick = timer0_ovf;
      3'h3: tick = eci_d && !ext_count_in;
      3'h4: tick = 1'b1;
      3'h5: tick = ext_clk && !extc_d && (ext8 == `CA_EXT8_LAST);
      default: tick = 1'b0;
    endcase
    // Counter is forced on while the watchdog guards the system.
    if (!(run_ctl || wdt_en) || (mode.idle_suspend && idle_mode)) begin // R10 R13 R22
      tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div12  <= 4'h0;
      div4   <= 2'h0;
      ext8   <= 3'h0;
      eci_d  <= 1'b1;
      extc_d <= 1'b0;
    end else begin
      div12  <= next_div12;
      div4   <= next_div4;
      ext8   <= next_ext8;
      eci_d  <= ext_count_in;
      extc_d <= ext_clk;
    end
  end

  // ----------------------------------------------------------------
  // Counter and watchdog
  // ----------------------------------------------------------------
  assign wdt_en    = mode.wdt_enable_bit | mode.wdt_lock; // R19
  assign wdt_load  = count[15:8] + cmp[W5][7:0]; // R15 R17
  assign wdt_fire  = wdt_en && tick && (count[7:0] == `CA_LOW_MAX)
                     && (cmp[W5][15:8] == count[15:8]); // R11 R16
  assign force_rst = wdt_en && sfr_we && (sfr_addr == `CA_ADDR_CTRL)
                     && sfr_wdata[W5]; // R18

  // Software writes lose to the watchdog freeze but a tick still counts.
  always_comb begin
    next_count = count;
    if (sfr_we && !wdt_en && sfr_addr == `CA_ADDR_CNT_LO) begin // R13
      next_count[7:0] = sfr_wdata;
    end
    if (sfr_we && !wdt_en && sfr_addr == `CA_ADDR_CNT_HI) begin
      next_count[15:8] = sfr_wdata;
    end
    if (tick) begin
      next_count = count + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count         <= 16'h0000; // R12
      wdt_reset_req <= 1'b0;
    end else begin
      count         <= next_count;
      wdt_reset_req <= wdt_fire || force_rst; // R23
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare modules
  // ----------------------------------------------------------------
  // Matching on the next count lets a zero compare win over the overflow.
  for (genvar n = 0; n < NM; n++) begin : g_mod
    logic pwm16_on;
    assign pwm16_on = mmode[n].compare_enable && mmode[n].pwm_enable
                      && mmode[n].pwm16_select; // R2 R3
    assign match[n] = tick && mmode[n].compare_enable
                      && !(n == W5 && wdt_en) && (next_count == cmp[n]);
    always_comb begin
      next_mmode[n] = mmode[n];
      next_cmp[n]   = cmp[n];
      next_pwm[n]   = pwm_out[n];
      if (sfr_we && sfr_addr == `CA_ADDR_CPM0 + 8'(n) && !(n == W5 && wdt_en)) begin // R13
        next_mmode[n] = sfr_wdata;
      end
      if (sfr_we && sfr_addr == `CA_ADDR_CPL0 + 8'(n)) begin
        next_cmp[n][7:0]             = sfr_wdata;
        next_mmode[n].compare_enable = 1'b0; // R6
      end
      if (sfr_we && sfr_addr == `CA_ADDR_CPH0 + 8'(n)) begin
        next_cmp[n][15:8]            = (n == W5 && wdt_en) ? wdt_load : sfr_wdata; // R15
        next_mmode[n].compare_enable = 1'b1; // R6
      end
      if (!pwm16_on || (n == W5 && wdt_en)) begin
        next_pwm[n] = 1'b0; // R7
      end else if (match[n]) begin
        next_pwm[n] = 1'b1; // R1
      end else if (tick && count == `CA_CNT_MAX) begin
        next_pwm[n] = 1'b0; // R1
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NM; i++) begin
      if (rst) begin
        mmode[i]   <= '0;
        cmp[i]     <= 16'h0000; // R12
        pwm_out[i] <= 1'b0;
      end else begin
        mmode[i]   <= next_mmode[i];
        cmp[i]     <= next_cmp[i];
        pwm_out[i] <= next_pwm[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, flags and mode register
  // ----------------------------------------------------------------
  // Hardware sets are ORed after the write so an event in a clear cycle survives.
  always_comb begin
    next_ovf_flag = ovf_flag;
    next_run_ctl  = run_ctl;
    next_mflag    = mflag;
    next_mode     = mode;
    if (sfr_we && sfr_addr == `CA_ADDR_CTRL) begin
      next_ovf_flag = sfr_wdata[`CA_CTRL_OVF];
      next_run_ctl  = sfr_wdata[`CA_CTRL_RUN]; // R14
      next_mflag    = sfr_wdata[5:0];
    end
    if (tick && count == `CA_CNT_MAX) begin
      next_ovf_flag = 1'b1; // R8
    end
    for (int i = 0; i < NM; i++) begin
      if (match[i] && mmode[i].match_flag_enable) begin
        next_mflag[i] = 1'b1; // R4 R9
      end
    end
    // While guarded only the enable and the lock may move.
    if (sfr_we && sfr_addr == `CA_ADDR_MODE) begin
      if (!wdt_en) begin
        next_mode        = sfr_wdata;
        next_mode.unused = 1'b0;
      end else begin
        next_mode.wdt_lock = mode.wdt_lock | sfr_wdata[5]; // R19
        if (!mode.wdt_lock) begin
          next_mode.wdt_enable_bit = sfr_wdata[6]; // R19
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_flag          <= 1'b0;
      run_ctl           <= 1'b0;
      mflag             <= 6'h00;
      mode              <= `CA_MODE_RESET; // R12
      counter_array_irq <= 1'b0;
    end else begin
      ovf_flag          <= next_ovf_flag;
      run_ctl           <= next_run_ctl;
      mflag             <= next_mflag;
      mode              <= next_mode;
      counter_array_irq <= (next_ovf_flag && next_mode.overflow_irq_enable)
                           || |(next_mflag & {next_mmode[5].flag_irq_enable,
                           next_mmode[4].flag_irq_enable, next_mmode[3].flag_irq_enable,
                           next_mmode[2].flag_irq_enable, next_mmode[1].flag_irq_enable,
                           next_mmode[0].flag_irq_enable}); // R8 R9
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Read data lags the address by one cycle; unmapped addresses read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_addr == `CA_ADDR_CTRL) begin
      next_rdata = {ovf_flag, run_ctl, mflag}; // R14
    end else if (sfr_addr == `CA_ADDR_MODE) begin
      next_rdata = mode;
    end else if (sfr_addr == `CA_ADDR_CNT_LO) begin
      next_rdata = count[7:0];
    end else if (sfr_addr == `CA_ADDR_CNT_HI) begin
      next_rdata = count[15:8];
    end
    for (int i = 0; i < NM; i++) begin
      if (sfr_addr == `CA_ADDR_CPM0 + 8'(i)) begin
        next_rdata = mmode[i];
      end else if (sfr_addr == `CA_ADDR_CPL0 + 8'(i)) begin
        next_rdata = cmp[i][7:0];
      end else if (sfr_addr == `CA_ADDR_CPH0 + 8'(i)) begin
        next_rdata = cmp[i][15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pwm_rise_a: assert property (g_mod[0].pwm16_on && match[0] |=> pwm_out[0]) // R1
    else $error("pwm output did not rise on match");
  pwm_fall_a: assert property (g_mod[0].pwm16_on && tick && count == 16'hffff
    && cmp[0] != 16'h0000 && !sfr_we |=> !pwm_out[0]) // R1
    else $error("pwm output did not fall on overflow");
  pwm_off_a: assert property (!mmode[0].compare_enable |=> !pwm_out[0]) // R7
    else $error("pwm output high with compare disabled");
  low_clear_a: assert property (sfr_we && sfr_addr == `CA_ADDR_CPL0 |=>
    !mmode[0].compare_enable) // R6
    else $error("low write left compare enabled");
  ovf_set_a: assert property (tick && count == 16'hffff |=> ovf_flag && count == 16'h0000) // R8
    else $error("rollover did not set overflow flag");
  flag_set_a: assert property (match[1] && mmode[1].match_flag_enable |=> mflag[1]) // R4
    else $error("match did not set module flag");
  cnt_frozen_a: assert property (wdt_en && sfr_we && sfr_addr == `CA_ADDR_CNT_HI
    && !tick |=> count == $past(count)) // R13
    else $error("counter written while guarded");
  wdt_load_a: assert property (wdt_en && sfr_we && sfr_addr == `CA_ADDR_CPH0 + 8'h05
    |=> cmp[W5][15:8] == $past(wdt_load)) // R15
    else $error("update did not load high plus offset");
  fire_a: assert property (disable iff (sys_rst) wdt_fire |=> wdt_reset_req ##1
    !wdt_reset_req && mode == `CA_MODE_RESET) // R16
    else $error("timeout did not give one reset pulse");
  force_rst_a: assert property (disable iff (sys_rst) force_rst |=> wdt_reset_req) // R18
    else $error("flag write did not force reset");
  lock_hold_a: assert property (mode.wdt_lock |=> wdt_en) // R19
    else $error("locked watchdog became disabled");

  pwm_rise_c: cover property (g_mod[0].pwm16_on && match[0]);
  wdt_fire_c: cover property (wdt_fire);
  ovf_flag_c: cover property (tick && count == 16'hffff);
endmodule

// ===== verif/counter_array_pwm16_watchdog_tb.sv
// Self-checking testbench for the counter array PWM and watchdog block.
`timescale 1ns/1ns
`include "counter_array_cfg.svh"
module counter_array_pwm16_watchdog_tb;
  logic       clk;
  logic       sys_rst;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_we;
  logic [7:0] sfr_rdata;
  logic       idle_mode;
  logic       timer0_ovf;
  logic       ext_count_in;
  logic       ext_clk;
  logic [5:0] pwm_out;
  logic       counter_array_irq;
  logic       wdt_reset_req;
  int         err_total;
  int         n_compared;
  int         n;
  int         v;
  int         exp_hi;
  int         k;
  int         b;
  int         prev;
  int         exp_cnt;

  // Timebase inputs rest at their quiet levels outside the timebase test; the count
  // input rests high so its falling-edge detector sees no false edge after reset.
  counter_array_pwm16_watchdog uut (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .sfr_addr          (sfr_addr),
    .sfr_wdata         (sfr_wdata),
    .sfr_we            (sfr_we),
    .sfr_rdata         (sfr_rdata),
    .idle_mode         (idle_mode),
    .timer0_ovf        (timer0_ovf),
    .ext_count_in      (ext_count_in),
    .ext_clk           (ext_clk),
    .pwm_out           (pwm_out),
    .counter_array_irq (counter_array_irq),
    .wdt_reset_req     (wdt_reset_req)
  );

  // The clock toggles every half period of 2 ns.
  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Every comparison is counted; a mismatch is reported at once.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A write is taken at the rising edge; an idle cycle follows so the strobe is never
  // lowered and raised in the same time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_we = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_we = 1'b0;
    @(negedge clk);
  endtask

  // Read data is registered, so it is looked at one cycle after the address.
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    @(negedge clk);
    check(what, {8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  // Bounded wait for the watchdog reset request, counting falling edges.
  task automatic wait_req(output int cnt, input int lim);
    cnt = 0;
    while (wdt_reset_req !== 1'b1 && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the roughly 5500 cycles the tests need.
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    idle_mode = 1'b0;
    timer0_ovf = 1'b0;
    ext_count_in = 1'b1;
    ext_clk = 1'b0;
    err_total = 0;
    n_compared = 0;
    n = $urandom(32'h427e92e7);
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;

    // Default watchdog: 256 ticks of system clock / 12, about 3072 cycles.
    wait_req(n, 4000);
    check("default timeout window", 16'(n >= 3055 && n <= 3080), 16'h1);
    @(negedge clk);
    check("reset request width", {15'h0, wdt_reset_req}, 16'h0);
    $display("test default_timeout done");

    // After the watchdog reset every register is back at its reset value.
    rdchk("control after reset", `CA_ADDR_CTRL, `CA_CTRL_RESET);
    rdchk("mode after reset", `CA_ADDR_MODE, `CA_MODE_RESET);
    rdchk("offset after reset", `CA_ADDR_CPL0 + 8'h05, 8'h00);
    rdchk("unmapped read", 8'hff, 8'h00);
    wr(`CA_ADDR_CNT_HI, 8'h33);
    rdchk("guarded count write", `CA_ADDR_CNT_HI, 8'h00);
    $display("test reset_values done");

    // Guarded mode bits stay frozen; a flag write forces an immediate reset.
    wr(`CA_ADDR_MODE, 8'h4e);
    rdchk("frozen clock select", `CA_ADDR_MODE, 8'h40);
    // The request stands for one cycle only, so the write is driven inline and the
    // request is looked at right after the write edge.
    sfr_we = 1'b1;
    sfr_addr = `CA_ADDR_CTRL;
    sfr_wdata = 8'h20;
    @(negedge clk);
    sfr_we = 1'b0;
    check("forced reset", {15'h0, wdt_reset_req}, 16'h1);
    @(negedge clk);
    check("forced reset width", {15'h0, wdt_reset_req}, 16'h0);
    $display("test forced_reset done");

    // 16-bit PWM on module 0 with the counter starting at 0xfe00, one page below the match.
    idle_mode = 1'($urandom % 2);
    v = $urandom % 256;
    exp_hi = 256 - v;
    wr(`CA_ADDR_MODE, 8'h00);
    wr(`CA_ADDR_MODE, 8'h08);
    rdchk("mode disabled sysclk", `CA_ADDR_MODE, 8'h08);
    wr(`CA_ADDR_CPM0, 8'hcb);
    wr(`CA_ADDR_CPL0, 8'(v));
    rdchk("low write clears enable", `CA_ADDR_CPM0, 8'h8b);
    wr(`CA_ADDR_CPH0, 8'hff);
    rdchk("high write sets enable", `CA_ADDR_CPM0, 8'hcb);
    wr(`CA_ADDR_CNT_LO, 8'h00);
    wr(`CA_ADDR_CNT_HI, 8'hfe);
    rdchk("stopped counter high", `CA_ADDR_CNT_HI, 8'hfe);
    wr(`CA_ADDR_CTRL, 8'h40);
    n = 0;
    while (pwm_out[0] !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check("pwm rises on match", {15'h0, pwm_out[0]}, 16'h1);
    n = 0;
    while (pwm_out[0] === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check("pwm high time", 16'(n), 16'(exp_hi));
    rdchk("overflow and match flags", `CA_ADDR_CTRL, 8'hc1);
    check("flag interrupt", {15'h0, counter_array_irq}, 16'h1);
    wr(`CA_ADDR_CTRL, 8'h40);
    rdchk("flags cleared", `CA_ADDR_CTRL, 8'h40);
    check("interrupt cleared", {15'h0, counter_array_irq}, 16'h0);
    check("idle modules low", {11'h000, pwm_out[5:1]}, 16'h0000);
    $display("test pwm16 done");

    // Each timebase source counts over a 99-edge window; the bench counts the events it
    // makes itself, and the free-running dividers allow one tick of phase slack.
    for (k = 0; k < 6; k++) begin
      wr(`CA_ADDR_CTRL, 8'h00);
      wr(`CA_ADDR_CNT_LO, 8'h00);
      wr(`CA_ADDR_CNT_HI, 8'h00);
      wr(`CA_ADDR_MODE, 8'(2 * k) | ((k == 4) ? 8'h80 : 8'h00));
      wr(`CA_ADDR_CTRL, 8'h40);
      exp_cnt = (k == 4) ? 3 : 0;
      prev = (k == 3) ? 1 : 0;
      for (n = 0; n < 96; n++) begin
        b = $urandom % 2;
        if (k == 2) begin
          timer0_ovf = 1'(b);
          exp_cnt += b;
        end else if (k == 3) begin
          ext_count_in = 1'(b);
          exp_cnt += (prev == 1 && b == 0) ? 1 : 0;
        end else if (k == 4) begin
          idle_mode = 1'(b);
          exp_cnt += 1 - b;
        end else if (k == 5) begin
          ext_clk = 1'(b);
          exp_cnt += (prev == 0 && b == 1) ? 1 : 0;
        end
        prev = b;
        @(negedge clk);
      end
      if (k == 5) begin
        exp_cnt = exp_cnt / 8;
      end
      timer0_ovf = 1'b0;
      ext_count_in = 1'b1;
      ext_clk = 1'b0;
      idle_mode = 1'b0;
      @(negedge clk);
      wr(`CA_ADDR_CTRL, 8'h00);
      sfr_addr = `CA_ADDR_CNT_LO;
      @(negedge clk);
      if (k < 2) begin
        v = (k == 0) ? 99 / 12 : 99 / 4;
        check("divided timebase", 16'(sfr_rdata >= v && sfr_rdata <= v + 1), 16'h0001);
      end else begin
        check("timebase count", {8'h00, sfr_rdata}, 16'(exp_cnt));
      end
    end
    $display("test timebase done");

    // Watchdog with a random offset: timeout is offset pages plus the remainder.
    idle_mode = 1'b0;
    v = $urandom % 3 + 1;
    wr(`CA_ADDR_CTRL, 8'h00);
    wr(`CA_ADDR_MODE, 8'h08);
    wr(`CA_ADDR_CPL0 + 8'h05, 8'(v));
    wr(`CA_ADDR_MODE, 8'h68);
    wr(`CA_ADDR_MODE, 8'h08);
    rdchk("lock keeps watchdog on", `CA_ADDR_MODE, 8'h68);
    wr(`CA_ADDR_CPH0 + 8'h05, 8'h5a);
    wait_req(n, 2000);
    check("offset timeout window", 16'(n >= 256 * v - 4 && n <= 256 * v + 260), 16'h1);
    $display("test offset_timeout done");
    give_verdict();
  end
endmodule
